// [mdc_bank.sv]
// MAC diagnostic counter bank: threshold setting, last packet strength,
// saturating event counters, host read and load, clear-channel decision.
// Assumes MAC event strobes are one-cycle pulses on i_ref_clk; the only
// pin-level input is the radio receive-busy level, synchronised here.
//
// Summary of operation
// R1: Threshold takes 0 (check off) or 0x28..0x64; resets to 0.
// R2: Before sending, compare channel energy; hold packet if above threshold.
// R3: Last receive strength holds newest packet magnitude; host cannot write it.
// R4: Last receive strength reads zero after reset until first packet.
// R5: Every counter clears to zero on reset.
// R6: Acknowledge-timeout counter adds one per timeout, several per unicast.
// R7: Sixteen-bit counters stop at 0xFFFF instead of wrapping.
// R8: Host load replaces a counter with the supplied value.
// R9: Blocked counter counts frames held by busy channel or active reception.
// R10: With threshold zero, only reception-held frames count as blocked.
// R11: Byte total counts every sent byte in 32 bits, loadable.
// R12: Good frame counter counts valid received frames.
// R13: Received acknowledge frames never count as good frames.
// R14: Give-up counter counts sends that exhaust retries without acknowledge.
// R15: Acknowledged-send counter counts unicasts while retry limit is nonzero.
// R16: Sweep visits each channel, reports peak energy, commas, final return.
// R17: Sweep parameter is accepted but changes nothing.
// R18: A host load wins over an event in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module mdc_bank import mdc_pkg::*; #(
	parameter int NUM_CH = 16,
	parameter int DWELL = 128
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Host command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [3:0] i_cmd_sel,
	input wire logic [31:0] i_cmd_param,
	output logic o_cmd_done,
	output logic o_cmd_error,
	output logic [31:0] o_cmd_rdata,
	// MAC transmit side
	input wire logic i_tx_req,
	input wire logic [7:0] i_chan_energy,
	input wire logic i_tx_unicast,
	input wire logic [7:0] i_mac_retry_limit,
	input wire logic i_tx_byte,
	input wire logic i_ack_timeout,
	input wire logic i_ack_giveup,
	output logic o_tx_grant,
	output logic o_tx_block,
	// MAC receive side
	input wire logic i_rx_busy_pin,
	input wire logic i_rx_frame,
	input wire logic i_rx_hdr_ok,
	input wire logic i_rx_is_ack,
	input wire logic [7:0] i_rx_strength,
	// Energy sweep
	input wire logic i_nrg_valid,
	input wire logic [7:0] i_nrg,
	output logic o_sweep_busy,
	output logic [7:0] o_sweep_chan,
	output logic o_rpt_valid,
	output logic [7:0] o_rpt_data,
	input wire logic i_rpt_ready
);
	// Saturating increment shared by all 16-bit counters
	function automatic logic [15:0] sat_inc16(input logic [15:0] v);
		return (v == MDC_CNT16_MAX) ? v : 16'(v + 16'h0001);
	endfunction

	// Host write strobe for one selector
	function automatic logic host_load(input logic v, input logic w,
		input logic [3:0] s, input logic [3:0] code);
		return v && w && (s == code);
	endfunction

	logic rx_busy_meta;
	logic rx_busy;
	logic [7:0] ccl_reg;
	logic [7:0] rssi_reg;
	logic [15:0] ackto_reg;
	logic [15:0] block_reg;
	logic [31:0] txbyte_reg;
	logic [15:0] good_reg;
	logic [15:0] giveup_reg;
	logic [15:0] acked_reg;
	logic energy_high;
	logic tx_held;
	logic ccl_ok;
	logic sweep_start;
	logic sw_busy;
	logic [7:0] sw_chan;
	logic sw_valid;
	logic [7:0] sw_data;

	// Receive-busy pin synchroniser
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rx_busy_meta <= 1'b0;
			rx_busy <= 1'b0;
		end else begin
			rx_busy_meta <= i_rx_busy_pin;
			rx_busy <= rx_busy_meta;
		end
	end

	// Clear-channel decision
	assign energy_high = (ccl_reg != MDC_CCL_OFF) && (i_chan_energy < ccl_reg); // [R2] [R10]
	assign tx_held = energy_high || rx_busy; // [R9]
	assign ccl_ok = (i_cmd_param[31:8] == 24'h000000) && ((i_cmd_param[7:0] == MDC_CCL_OFF)
		|| (i_cmd_param[7:0] >= MDC_CCL_MIN && i_cmd_param[7:0] <= MDC_CCL_MAX));
	assign sweep_start = i_cmd_valid && (i_cmd_sel == MDC_SEL_SWEEP) && !sw_busy; // [R17]

	// Transmit grant and block outputs, one pulse per request
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_tx_grant <= 1'b0;
			o_tx_block <= 1'b0;
		end else begin
			o_tx_grant <= i_tx_req && !tx_held; // [R2]
			o_tx_block <= i_tx_req && tx_held; // [R2]
		end
	end

	// Threshold setting
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ccl_reg <= MDC_CCL_RST; // [R1]
		end else if (host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_CCL) && ccl_ok) begin
			ccl_reg <= i_cmd_param[7:0]; // [R1]
		end
	end

	// Last received packet strength
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rssi_reg <= MDC_RSSI_RST; // [R4]
		end else if (i_rx_frame && i_rx_hdr_ok) begin
			rssi_reg <= i_rx_strength; // [R3]
		end
	end

	// Acknowledge timeout counter
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ackto_reg <= MDC_CNT16_RST; // [R5]
		end else if (host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_ACKTO)) begin
			ackto_reg <= i_cmd_param[15:0]; // [R8] [R18]
		end else if (i_ack_timeout) begin
			ackto_reg <= sat_inc16(ackto_reg); // [R6] [R7]
		end
	end

	// Blocked frame counter
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			block_reg <= MDC_CNT16_RST; // [R5]
		end else if (host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_BLOCK)) begin
			block_reg <= i_cmd_param[15:0]; // [R8] [R18]
		end else if (i_tx_req && tx_held) begin
			block_reg <= sat_inc16(block_reg); // [R9] [R7]
		end
	end

	// Transmitted byte total
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			txbyte_reg <= MDC_CNT32_RST; // [R5]
		end else if (host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_TXBYTE)) begin
			txbyte_reg <= i_cmd_param; // [R11] [R18]
		end else if (i_tx_byte && txbyte_reg != MDC_CNT32_MAX) begin
			txbyte_reg <= 32'(txbyte_reg + 32'h00000001); // [R11]
		end
	end

	// Good frame counter, acknowledge frames excluded
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			good_reg <= MDC_CNT16_RST; // [R5]
		end else if (host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_GOOD)) begin
			good_reg <= i_cmd_param[15:0]; // [R8] [R18]
		end else if (i_rx_frame && i_rx_hdr_ok && !i_rx_is_ack) begin
			good_reg <= sat_inc16(good_reg); // [R12] [R13] [R7]
		end
	end

	// Retry exhaustion counter
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			giveup_reg <= MDC_CNT16_RST; // [R5]
		end else if (host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_GIVEUP)) begin
			giveup_reg <= i_cmd_param[15:0]; // [R8] [R18]
		end else if (i_ack_giveup) begin
			giveup_reg <= sat_inc16(giveup_reg); // [R14] [R7]
		end
	end

	// Acknowledged unicast counter, counted on grant
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			acked_reg <= MDC_CNT16_RST; // [R5]
		end else if (host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_ACKED)) begin
			acked_reg <= i_cmd_param[15:0]; // [R8] [R18]
		end else if (i_tx_req && !tx_held && i_tx_unicast && i_mac_retry_limit != 8'h00) begin
			acked_reg <= sat_inc16(acked_reg); // [R15] [R7]
		end
	end

	// Host command answer, one cycle after the request
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_cmd_done <= 1'b0;
			o_cmd_error <= 1'b0;
			o_cmd_rdata <= 32'h00000000;
		end else begin
			o_cmd_done <= i_cmd_valid;
			o_cmd_error <= 1'b0;
			o_cmd_rdata <= 32'h00000000;
			if (i_cmd_valid) begin
				case (i_cmd_sel)
					MDC_SEL_CCL: begin
						o_cmd_rdata <= {24'h000000, ccl_reg};
						o_cmd_error <= i_cmd_write && !ccl_ok; // [R1]
					end
					MDC_SEL_RSSI: begin
						o_cmd_rdata <= {24'h000000, rssi_reg};
						o_cmd_error <= i_cmd_write; // [R3]
					end
					MDC_SEL_ACKTO: o_cmd_rdata <= {16'h0000, ackto_reg};
					MDC_SEL_BLOCK: o_cmd_rdata <= {16'h0000, block_reg};
					MDC_SEL_TXBYTE: o_cmd_rdata <= txbyte_reg;
					MDC_SEL_GOOD: o_cmd_rdata <= {16'h0000, good_reg};
					MDC_SEL_GIVEUP: o_cmd_rdata <= {16'h0000, giveup_reg};
					MDC_SEL_ACKED: o_cmd_rdata <= {16'h0000, acked_reg};
					MDC_SEL_SWEEP: o_cmd_error <= sw_busy;
					default: o_cmd_error <= 1'b1;
				endcase
			end
		end
	end

	// Energy sweep engine
	mdc_sweep #(
		.NUM_CH(NUM_CH),
		.DWELL(DWELL)
	) u_sweep (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_start(sweep_start),
		.i_nrg_valid(i_nrg_valid),
		.i_nrg(i_nrg),
		.o_busy(sw_busy),
		.o_chan(sw_chan),
		.o_rpt_valid(sw_valid),
		.o_rpt_data(sw_data),
		.i_rpt_ready(i_rpt_ready)
	);

	// Register sweep busy and channel outputs; report valid and data pass straight through
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_sweep_busy <= 1'b0;
			o_sweep_chan <= 8'h00;
		end else begin
			o_sweep_busy <= sw_busy;
			o_sweep_chan <= sw_chan;
		end
	end
	assign o_rpt_valid = sw_valid;
	assign o_rpt_data = sw_data;

	// Threshold stays within its legal set
	a_ccl_legal: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R1]
		ccl_reg == MDC_CCL_OFF || (ccl_reg >= MDC_CCL_MIN && ccl_reg <= MDC_CCL_MAX))
		else $error("threshold out of range");
	// Refused threshold leaves setting unchanged
	a_ccl_refuse: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R1]
		host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_CCL) && !ccl_ok
		|=> $stable(ccl_reg))
		else $error("refused threshold was stored");
	// Held request yields block pulse, not grant
	a_tx_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R2]
		i_tx_req && tx_held |=> o_tx_block && !o_tx_grant)
		else $error("held frame was granted");
	// Clear request is granted
	a_tx_grant: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R2]
		i_tx_req && !tx_held |=> o_tx_grant && !o_tx_block)
		else $error("clear frame was not granted");
	// Strength only changes on a received frame
	a_rssi_stable: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R3]
		!(i_rx_frame && i_rx_hdr_ok) |=> $stable(rssi_reg))
		else $error("strength changed without frame");
	// Strength write answered with error
	a_rssi_ro: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R3]
		host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_RSSI) |=> o_cmd_error)
		else $error("strength write not refused");
	// Zero after reset until first frame
	a_rssi_reset: assert property (@(posedge i_ref_clk) // [R4]
		i_srst |=> rssi_reg == MDC_RSSI_RST)
		else $error("strength not cleared");
	// Counters cleared by reset
	a_cnt_reset: assert property (@(posedge i_ref_clk) // [R5]
		i_srst |=> ackto_reg == 16'h0000 && txbyte_reg == 32'h00000000 && good_reg == 16'h0000)
		else $error("counter not cleared");
	// Timeout counts up by one
	a_ackto_inc: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R6]
		i_ack_timeout && !host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_ACKTO)
		&& ackto_reg != MDC_CNT16_MAX |=> ackto_reg == 16'($past(ackto_reg) + 16'h0001))
		else $error("timeout count wrong");
	// Saturated counter holds
	a_sat_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R7]
		good_reg == MDC_CNT16_MAX && !i_cmd_valid |=> good_reg == MDC_CNT16_MAX)
		else $error("counter wrapped");
	// Load wins over event
	a_load_wins: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R8] [R18]
		host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_BLOCK)
		|=> block_reg == $past(i_cmd_param[15:0]))
		else $error("load lost");
	// Every command answered one cycle later
	a_cmd_done: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R8]
		i_cmd_valid |=> o_cmd_done)
		else $error("command not answered");
	// Blocked request counted
	a_block_inc: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R9]
		i_tx_req && tx_held && !host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_BLOCK)
		&& block_reg != MDC_CNT16_MAX |=> block_reg == 16'($past(block_reg) + 16'h0001))
		else $error("blocked count wrong");
	// Reception in progress always blocks
	a_rx_block: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R9] [R10]
		i_tx_req && rx_busy |=> o_tx_block)
		else $error("frame sent during reception");
	// Off threshold blocks only on reception
	a_ccl_off: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R10]
		ccl_reg == MDC_CCL_OFF && !rx_busy && i_tx_req |=> o_tx_grant)
		else $error("blocked with check off");
	// Byte total counts each sent byte
	a_txbyte_inc: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R11]
		i_tx_byte && !host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_TXBYTE)
		&& txbyte_reg != MDC_CNT32_MAX
		|=> txbyte_reg == 32'($past(txbyte_reg) + 32'h00000001))
		else $error("byte total wrong");
	// Good frame counted
	a_good_inc: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R12]
		i_rx_frame && i_rx_hdr_ok && !i_rx_is_ack && good_reg != MDC_CNT16_MAX
		&& !host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_GOOD)
		|=> good_reg == 16'($past(good_reg) + 16'h0001))
		else $error("good count wrong");
	// Acknowledge frames never counted good
	a_ack_nogood: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R13]
		i_rx_is_ack && !i_cmd_valid |=> $stable(good_reg))
		else $error("ack counted as good");
	// Retry exhaustion counted
	a_giveup_inc: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R14]
		i_ack_giveup && giveup_reg != MDC_CNT16_MAX
		&& !host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_GIVEUP)
		|=> giveup_reg == 16'($past(giveup_reg) + 16'h0001))
		else $error("give-up count wrong");
	// No acknowledged sends while retry limit is zero
	a_acked_off: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R15]
		i_mac_retry_limit == 8'h00
		&& !host_load(i_cmd_valid, i_cmd_write, i_cmd_sel, MDC_SEL_ACKED) |=> $stable(acked_reg))
		else $error("acked send counted with retries off");
endmodule
`default_nettype wire

// [mdc_pkg.sv]
// Package for the MAC diagnostic counter bank: command codes, widths, limits.
// Assumes a single clock domain; included by the counter bank and its sweep unit.
package mdc_pkg;
	// Command selector codes on the host command port
	localparam logic [3:0] MDC_SEL_CCL = 4'h0;
	localparam logic [3:0] MDC_SEL_RSSI = 4'h1;
	localparam logic [3:0] MDC_SEL_ACKTO = 4'h2;
	localparam logic [3:0] MDC_SEL_BLOCK = 4'h3;
	localparam logic [3:0] MDC_SEL_TXBYTE = 4'h4;
	localparam logic [3:0] MDC_SEL_GOOD = 4'h5;
	localparam logic [3:0] MDC_SEL_GIVEUP = 4'h6;
	localparam logic [3:0] MDC_SEL_ACKED = 4'h7;
	localparam logic [3:0] MDC_SEL_SWEEP = 4'h8;
	// Clear-channel threshold limits (magnitude, -dBm)
	localparam logic [7:0] MDC_CCL_OFF = 8'h00;
	localparam logic [7:0] MDC_CCL_MIN = 8'h28;
	localparam logic [7:0] MDC_CCL_MAX = 8'h64;
	localparam logic [7:0] MDC_CCL_RST = 8'h00;
	// Counter reset values and saturation limit
	localparam logic [15:0] MDC_CNT16_RST = 16'h0000;
	localparam logic [15:0] MDC_CNT16_MAX = 16'hFFFF;
	localparam logic [31:0] MDC_CNT32_RST = 32'h00000000;
	localparam logic [31:0] MDC_CNT32_MAX = 32'hFFFFFFFF;
	localparam logic [7:0] MDC_RSSI_RST = 8'h00;
	// Sweep report characters
	localparam logic [7:0] MDC_CHR_COMMA = 8'h2C;
	localparam logic [7:0] MDC_CHR_CR = 8'h0D;
	localparam logic [7:0] MDC_NRG_FLOOR = 8'hFF;
	// Sweep state machine
	typedef enum logic [1:0] {
		MDC_SW_IDLE = 2'b00,
		MDC_SW_MEAS = 2'b01,
		MDC_SW_VAL = 2'b10,
		MDC_SW_SEP = 2'b11
	} mdc_sweep_e;
endpackage

// [mdc_sweep.sv]
// Energy sweep unit: steps channels, tracks each channel's peak energy and
// streams one value byte plus separator per channel. Same clock as the bank.
`timescale 1ns/1ps
`default_nettype none
module mdc_sweep import mdc_pkg::*; #(
	parameter int NUM_CH = 16,
	parameter int DWELL = 128
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Start and measurement
	input wire logic i_start,
	input wire logic i_nrg_valid,
	input wire logic [7:0] i_nrg,
	// Channel select to the radio
	output logic o_busy,
	output logic [7:0] o_chan,
	// Report stream
	output logic o_rpt_valid,
	output logic [7:0] o_rpt_data,
	input wire logic i_rpt_ready
);
	localparam int DW = $clog2(DWELL + 1);
	mdc_sweep_e state_reg;
	logic [DW-1:0] dwell_reg;
	logic [7:0] peak_reg;
	logic last_ch;
	assign last_ch = (o_chan == 8'(NUM_CH - 1));
	assign o_busy = (state_reg != MDC_SW_IDLE);

	// Sequence: dwell on channel, emit peak, emit comma, then carriage return after the last channel's comma
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_reg <= MDC_SW_IDLE;
			dwell_reg <= '0;
			o_chan <= 8'h00;
			o_rpt_valid <= 1'b0;
			o_rpt_data <= 8'h00;
		end else begin
			unique case (state_reg)
				MDC_SW_IDLE: begin
					if (i_start) begin
						state_reg <= MDC_SW_MEAS;
						o_chan <= 8'h00;
						dwell_reg <= '0;
					end
				end
				MDC_SW_MEAS: begin
					dwell_reg <= DW'(dwell_reg + 1'b1);
					if (dwell_reg == DW'(DWELL - 1)) begin
						state_reg <= MDC_SW_VAL;
						o_rpt_valid <= 1'b1;
						o_rpt_data <= peak_reg;
					end
				end
				MDC_SW_VAL: begin
					if (i_rpt_ready) begin
						state_reg <= MDC_SW_SEP;
						o_rpt_data <= MDC_CHR_COMMA;
					end
				end
				MDC_SW_SEP: begin
					if (i_rpt_ready) begin
						if (last_ch && o_rpt_data == MDC_CHR_COMMA) begin
							o_rpt_data <= MDC_CHR_CR; // [R16]
						end else if (last_ch) begin
							o_rpt_valid <= 1'b0;
							state_reg <= MDC_SW_IDLE;
						end else begin
							o_rpt_valid <= 1'b0;
							o_chan <= 8'(o_chan + 8'h01); // [R16]
							dwell_reg <= '0;
							state_reg <= MDC_SW_MEAS;
						end
					end
				end
			endcase
		end
	end

	// Peak tracker: smallest -dBm magnitude is the strongest energy
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			peak_reg <= MDC_NRG_FLOOR;
		end else if (state_reg != MDC_SW_MEAS) begin
			peak_reg <= MDC_NRG_FLOOR;
		end else if (i_nrg_valid && i_nrg < peak_reg) begin
			peak_reg <= i_nrg; // [R16]
		end
	end
endmodule
`default_nettype wire

// [mdc_host.sv]
// Host processor model: issues one configuration command at a time.
// Assumes the bank answers with done exactly one cycle after taking a command.
`timescale 1ns/1ps
`default_nettype none
module mdc_host (
	// Clock
	input wire logic i_ref_clk,
	// Command request
	output logic o_cmd_valid,
	output logic o_cmd_write,
	output logic [3:0] o_cmd_sel,
	output logic [31:0] o_cmd_param,
	// Command answer
	input wire logic i_cmd_done,
	input wire logic i_cmd_error,
	input wire logic [31:0] i_cmd_rdata
);
	// Idle bus at time zero
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_write = 1'b0;
		o_cmd_sel = 4'hF;
		o_cmd_param = 32'hA5A5A5A5;
	end

	// One command; answer taken while done stands, then fields inverted
	task automatic cmd(input logic w, input logic [3:0] s, input logic [31:0] p,
		output logic [31:0] d, output logic e, output logic ok);
		@(negedge i_ref_clk);
		o_cmd_valid = 1'b1;
		o_cmd_write = w;
		o_cmd_sel = s;
		o_cmd_param = p;
		@(negedge i_ref_clk);
		d = i_cmd_rdata;
		e = i_cmd_error;
		ok = i_cmd_done;
		o_cmd_valid = 1'b0;
		o_cmd_write = ~w;
		o_cmd_sel = ~s;
		o_cmd_param = ~p;
	endtask
endmodule
`default_nettype wire

// [tb_mac_diagnostic_counters.sv]
// Testbench for the diagnostic counter bank: commands, frames, sweep.
// Assumes a short sweep (2 channels, 4-cycle dwell) and the host model.
`timescale 1ns/1ps
`default_nettype none
module tb_mac_diagnostic_counters import mdc_pkg::*; ;
	logic clk = 1'b0, srst = 1'b1, c_valid, c_write, done, error;
	logic [3:0] c_sel;
	logic [31:0] c_param, rdata;
	logic [2:0] ev = 3'b000;
	logic tx_req = 1'b0, unicast = 1'b0, busy_pin = 1'b0, rx_frame = 1'b0;
	logic hdr_ok = 1'b0, is_ack = 1'b0, rpt_ready = 1'b0, grant, block;
	logic sw_busy, rpt_valid;
	logic [7:0] energy = 8'h00, retry = 8'h03, rx_str = 8'h00, sw_chan, rpt_data;
	logic [7:0] sweep_exp [5] = '{8'h33, 8'h2C, 8'h33, 8'h2C, 8'h0D};
	logic [7:0] nrg = 8'h33;
	int err_total = 0, n_tests = 0, cyc = 0, k;

	// Clock at 100 MHz
	always #5 clk = ~clk;

	// Energy samples alternate so the peak must really be tracked
	always @(negedge clk) nrg <= (nrg == 8'h33) ? 8'h48 : 8'h33;

	mdc_host host_u (.i_ref_clk(clk), .o_cmd_valid(c_valid), .o_cmd_write(c_write),
		.o_cmd_sel(c_sel), .o_cmd_param(c_param), .i_cmd_done(done),
		.i_cmd_error(error), .i_cmd_rdata(rdata));

	mdc_bank #(.NUM_CH(2), .DWELL(4)) dut_u (.i_ref_clk(clk), .i_srst(srst),
		.i_cmd_valid(c_valid), .i_cmd_write(c_write), .i_cmd_sel(c_sel),
		.i_cmd_param(c_param), .o_cmd_done(done), .o_cmd_error(error),
		.o_cmd_rdata(rdata), .i_tx_req(tx_req), .i_chan_energy(energy),
		.i_tx_unicast(unicast), .i_mac_retry_limit(retry), .i_tx_byte(ev[0]),
		.i_ack_timeout(ev[1]), .i_ack_giveup(ev[2]), .o_tx_grant(grant),
		.o_tx_block(block), .i_rx_busy_pin(busy_pin), .i_rx_frame(rx_frame),
		.i_rx_hdr_ok(hdr_ok), .i_rx_is_ack(is_ack), .i_rx_strength(rx_str),
		.i_nrg_valid(1'b1), .i_nrg(nrg), .o_sweep_busy(sw_busy),
		.o_sweep_chan(sw_chan), .o_rpt_valid(rpt_valid), .o_rpt_data(rpt_data),
		.i_rpt_ready(rpt_ready));

	task automatic print_verdict();
		$display("errors %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			$display("unexpected at %0t: value %h, want %h", $time, got, want);
			err_total++;
		end
	endtask

	// Flag compare
	task automatic chkf(input logic got, input logic want);
		n_tests++;
		if (got !== want) begin
			$display("unexpected at %0t: flag %b, want %b", $time, got, want);
			err_total++;
		end
	endtask

	// Command with done, error and read data checked
	task automatic acc(input logic w, input logic [3:0] s, input logic [31:0] p,
		input logic [31:0] xd, input logic xe);
		logic [31:0] d;
		logic e, ok;
		host_u.cmd(w, s, p, d, e, ok);
		chkf(ok, 1'b1);
		chkf(e, xe);
		if (!w) chk(d, xd);
	endtask

	// Event pulses, one cycle each with a gap
	task automatic pulse(input logic [2:0] m, input int n);
		repeat (n) begin
			@(negedge clk) ev = m;
			@(negedge clk) ev = 3'b000;
		end
	endtask

	// Transmit request; grant or block one cycle later
	task automatic tx(input logic [7:0] en, input logic u, input logic xb);
		@(negedge clk);
		tx_req = 1'b1;
		energy = en;
		unicast = u;
		@(negedge clk);
		chkf(grant, ~xb);
		chkf(block, xb);
		tx_req = 1'b0;
		energy = ~en;
	endtask

	// Received frame
	task automatic rx(input logic h, input logic a, input logic [7:0] s);
		@(negedge clk);
		{rx_frame, hdr_ok, is_ack, rx_str} = {1'b1, h, a, s};
		@(negedge clk);
		{rx_frame, hdr_ok, is_ack, rx_str} = {1'b0, ~h, ~a, ~s};
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
	end

	// Main sequence
	initial begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		for (int s = 0; s < 8; s++) acc(1'b0, s[3:0], 0, 0, 1'b0);
		acc(1'b1, MDC_SEL_RSSI, 32'h11, 0, 1'b1);
		acc(1'b1, MDC_SEL_CCL, 32'h27, 0, 1'b1);
		acc(1'b1, MDC_SEL_CCL, 32'h65, 0, 1'b1);
		acc(1'b1, MDC_SEL_CCL, 32'h128, 0, 1'b1);
		acc(1'b1, MDC_SEL_CCL, 32'h64, 0, 1'b0);
		acc(1'b0, MDC_SEL_CCL, 0, 32'h64, 1'b0);
		acc(1'b1, MDC_SEL_CCL, 32'h28, 0, 1'b0);
		acc(1'b0, MDC_SEL_CCL, 0, 32'h28, 1'b0);
		tx(8'h20, 1'b1, 1'b1);
		tx(8'h28, 1'b1, 1'b0);
		retry = 8'h00;
		tx(8'h50, 1'b1, 1'b0);
		retry = 8'h03;
		acc(1'b0, MDC_SEL_ACKED, 0, 1, 1'b0);
		acc(1'b1, MDC_SEL_CCL, 0, 0, 1'b0);
		tx(8'h10, 1'b0, 1'b0);
		busy_pin = 1'b1;
		repeat (4) @(negedge clk);
		tx(8'h50, 1'b0, 1'b1);
		busy_pin = 1'b0;
		repeat (4) @(negedge clk);
		acc(1'b0, MDC_SEL_BLOCK, 0, 2, 1'b0);
		pulse(3'b010, 2);
		acc(1'b0, MDC_SEL_ACKTO, 0, 2, 1'b0);
		acc(1'b1, MDC_SEL_ACKTO, 32'hFFFE, 0, 1'b0);
		pulse(3'b010, 3);
		acc(1'b0, MDC_SEL_ACKTO, 0, 32'hFFFF, 1'b0);
		pulse(3'b001, 3);
		acc(1'b0, MDC_SEL_TXBYTE, 0, 3, 1'b0);
		acc(1'b1, MDC_SEL_TXBYTE, 32'hFFFFFFFE, 0, 1'b0);
		pulse(3'b001, 2);
		acc(1'b0, MDC_SEL_TXBYTE, 0, 32'hFFFFFFFF, 1'b0);
		pulse(3'b100, 1);
		acc(1'b0, MDC_SEL_GIVEUP, 0, 1, 1'b0);
		fork
			acc(1'b1, MDC_SEL_GIVEUP, 32'h5, 0, 1'b0);
			pulse(3'b100, 1);
		join
		acc(1'b0, MDC_SEL_GIVEUP, 0, 5, 1'b0);
		rx(1'b1, 1'b0, 8'h60);
		acc(1'b0, MDC_SEL_RSSI, 0, 32'h60, 1'b0);
		rx(1'b1, 1'b1, 8'h70);
		rx(1'b0, 1'b0, 8'h44);
		acc(1'b0, MDC_SEL_GOOD, 0, 1, 1'b0);
		acc(1'b1, MDC_SEL_GOOD, 32'hFFFF, 0, 1'b0);
		rx(1'b1, 1'b0, 8'h61);
		acc(1'b0, MDC_SEL_GOOD, 0, 32'hFFFF, 1'b0);
		acc(1'b1, MDC_SEL_SWEEP, 32'h5A, 0, 1'b0);
		acc(1'b1, MDC_SEL_SWEEP, 0, 0, 1'b1);
		// Report stream taken with the consumer stalling between bytes
		for (int i = 0; i < 5; i++) begin
			k = 0;
			while (rpt_valid !== 1'b1 && k < 300) begin
				@(negedge clk);
				k++;
			end
			chk(rpt_data, sweep_exp[i]);
			chkf(sw_busy, 1'b1);
			chk(sw_chan, (i > 1) ? 1 : 0);
			rpt_ready = 1'b1;
			@(negedge clk);
			rpt_ready = 1'b0;
			@(negedge clk);
		end
		repeat (3) @(negedge clk);
		chkf(sw_busy, 1'b0);
		// Mid-run reset clears everything again
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		for (int s = 0; s < 8; s++) acc(1'b0, s[3:0], 0, 0, 1'b0);
		acc(1'b0, 4'h9, 0, 0, 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire
